/* File: hdl/swd_software_watchdog_timer.sv */
// software watchdog timer with apb register access
`timescale 1ns/100ps
`default_nettype none
module swd_software_watchdog_timer
  import swd_pkg::*;
#(
  parameter logic [18:0] BUS_SHORT_COUNT = SWD_BUS_SHORT,
  parameter logic [18:0] BUS_LONG_COUNT  = SWD_BUS_LONG,
  parameter logic [18:0] SLOW_LONG_COUNT = SWD_SLOW_LONG
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        slow_clk_pin,
  input  wire logic        debug_mode,
  input  wire logic        stop_mode,
  output logic             system_reset
);

  logic [SWD_CNT_W-1:0] count_reg;
  logic [SWD_CNT_W-1:0] limit;
  logic                 enable_reg;
  logic                 timeout_reg;
  logic                 clksel_reg;
  logic                 lock_one_reg;
  logic                 lock_two_reg;
  logic                 fired_reg;
  logic                 slow_meta_reg;
  logic                 slow_sync_reg;
  logic                 slow_prev_reg;
  logic                 stop_prev_reg;
  logic                 access;
  logic                 wr_one;
  logic                 wr_two;
  logic                 wr_stat;
  logic                 tick;
  logic                 service;
  logic                 overflow;

  // address decode for the error answer; the read mux decodes with its own case
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == SWD_OFS_OPTIONS_ONE) || (a == SWD_OFS_OPTIONS_TWO) ||
             (a == SWD_OFS_RESET_STAT) || (a == SWD_OFS_COUNT);
  endfunction

  // a write takes effect only in the access cycle where pready is high
  assign access  = psel && penable && pready;
  assign wr_one  = access && pwrite && (paddr == SWD_OFS_OPTIONS_ONE);
  assign wr_two  = access && pwrite && (paddr == SWD_OFS_OPTIONS_TWO);
  assign wr_stat = access && pwrite && (paddr == SWD_OFS_RESET_STAT);

  // one wait-free access: answer prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped(paddr);
      prdata  <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          SWD_OFS_OPTIONS_ONE: begin
            prdata[SWD_BIT_ENABLE]  <= enable_reg;
            prdata[SWD_BIT_TIMEOUT] <= timeout_reg;
          end
          SWD_OFS_OPTIONS_TWO: prdata[SWD_BIT_CLKSEL] <= clksel_reg;
          SWD_OFS_RESET_STAT:  prdata[SWD_BIT_FIRED]  <= fired_reg;
          SWD_OFS_COUNT:       prdata[SWD_CNT_W-1:0]  <= count_reg;
          default:             prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // write-once option register one; the lock stops runaway code from
  // disabling the watchdog later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg   <= SWD_RST_ENABLE;
      timeout_reg  <= SWD_RST_TIMEOUT;
      lock_one_reg <= 1'b0;
    end else if (wr_one && !lock_one_reg) begin
      enable_reg   <= pwdata[SWD_BIT_ENABLE];
      timeout_reg  <= pwdata[SWD_BIT_TIMEOUT];
      lock_one_reg <= 1'b1;
    end
  end

  // write-once option register two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clksel_reg   <= SWD_RST_CLKSEL;
      lock_two_reg <= 1'b0;
    end else if (wr_two && !lock_two_reg) begin
      clksel_reg   <= pwdata[SWD_BIT_CLKSEL];
      lock_two_reg <= 1'b1;
    end
  end

  // slow source arrives from outside: two flops, then edge detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_meta_reg <= 1'b0;
      slow_sync_reg <= 1'b0;
      slow_prev_reg <= 1'b0;
      stop_prev_reg <= 1'b0;
    end else begin
      slow_meta_reg <= slow_clk_pin;
      slow_sync_reg <= slow_meta_reg;
      slow_prev_reg <= slow_sync_reg;
      stop_prev_reg <= stop_mode;
    end
  end

  // counter clock choice and overflow count follow live selection
  assign tick = clksel_reg ? 1'b1 : (slow_sync_reg && !slow_prev_reg);
  always_comb begin
    case ({clksel_reg, timeout_reg})
      2'b00:   limit = SWD_SLOW_SHORT;
      2'b01:   limit = SLOW_LONG_COUNT;
      2'b10:   limit = BUS_SHORT_COUNT;
      default: limit = BUS_LONG_COUNT;
    endcase
  end

  // service sources: status write and first option writes
  assign service  = wr_stat || (wr_one && !lock_one_reg) ||
                    (wr_two && !lock_two_reg);
  // greater-or-equal catches a count left above a newly shortened limit
  assign overflow = enable_reg && tick && !debug_mode && !stop_mode &&
                    (count_reg >= limit - 19'h00001);

  // watchdog counter; service wins over a simultaneous increment
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
    end else if (service || !enable_reg) begin
      count_reg <= '0;
    end else if (!clksel_reg && stop_mode && !stop_prev_reg) begin
      count_reg <= '0;
    end else if (debug_mode || stop_mode) begin
      count_reg <= count_reg;
    end else if (overflow) begin
      count_reg <= '0;
    end else if (tick) begin
      count_reg <= count_reg + 19'h00001;
    end
  end

  // reset request pulse; only hardware sets the status flag, a write
  // to the status address never alters it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_reset <= 1'b0;
      fired_reg    <= 1'b0;
    end else begin
      system_reset <= overflow && !service;
      if (overflow && !service) begin
        fired_reg <= 1'b1;
      end
    end
  end

endmodule // swd_software_watchdog_timer
`default_nettype wire

/* File: hdl/swd_pkg.sv */
// package of constants for the software watchdog timer
package swd_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0]  SWD_OFS_OPTIONS_ONE = 8'h00;
  localparam logic [7:0]  SWD_OFS_OPTIONS_TWO = 8'h04;
  localparam logic [7:0]  SWD_OFS_RESET_STAT  = 8'h08;
  localparam logic [7:0]  SWD_OFS_COUNT       = 8'h0C;
  // field positions
  localparam int          SWD_BIT_ENABLE      = 7;   // in system_options_one
  localparam int          SWD_BIT_TIMEOUT     = 6;   // in system_options_one
  localparam int          SWD_BIT_CLKSEL      = 7;   // in system_options_two
  localparam int          SWD_BIT_FIRED       = 5;   // in reset_source_status
  // reset values: enabled, long time-out, slow clock
  localparam logic        SWD_RST_ENABLE      = 1'b1;
  localparam logic        SWD_RST_TIMEOUT     = 1'b1;
  localparam logic        SWD_RST_CLKSEL      = 1'b0;
  // counter width and overflow counts in cycles of the selected clock
  localparam int          SWD_CNT_W           = 19;
  localparam logic [18:0] SWD_SLOW_SHORT      = 19'h00400;  // 2^10
  localparam logic [18:0] SWD_SLOW_LONG       = 19'h02000;  // 2^13
  localparam logic [18:0] SWD_BUS_SHORT       = 19'h02000;  // 2^13
  localparam logic [18:0] SWD_BUS_LONG        = 19'h40000;  // 2^18
endpackage : swd_pkg

/* File: testbench/swd_chk.sv */
// checker on the watchdog register bus and reset output
`timescale 1ns/100ps
`default_nettype none
module swd_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        debug_mode,
  input wire logic        stop_mode,
  input wire logic        system_reset
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // read access in its answer cycle
  wire logic rd_acc = pready && !pwrite;
  a_ready_setup: assert property (psel && !penable |=> pready) else $error("ready missing");
  a_err_unmapped: assert property (pready && paddr[7:4] != 4'h0 |-> pslverr) else $error("no err");
  a_reset_pulse: assert property (system_reset |=> !system_reset) else $error("long pulse");
  a_debug_hold: assert property ($past(debug_mode) |-> !system_reset) else $error("dbg");
  a_stop_hold: assert property ($past(stop_mode) |-> !system_reset) else $error("stop");
  // a service clears the count, so no overflow can follow soon after
  a_service_clear: assert property (
    pready && pwrite && paddr == 8'h08 |=> !system_reset [*8])
    else $error("reset after service");
  a_status_bits: assert property (
    rd_acc && paddr == 8'h08 |-> prdata[31:6] == 26'h0 && prdata[4:0] == 5'h00)
    else $error("status bits");
  a_count_width: assert property (
    rd_acc && paddr == 8'h0C |-> prdata[31:19] == 13'h0)
    else $error("count width");
  c_fired: cover property (system_reset);
  c_service: cover property (pready && pwrite && paddr == 8'h08);
  c_err: cover property (pslverr);
endmodule // swd_chk
`default_nettype wire

/* File: testbench/tb_software_watchdog_timer.sv */
// self-checking bench for the software watchdog timer
`timescale 1ns/100ps
`default_nettype none
module tb_software_watchdog_timer;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, debug_mode = 1'b0, stop_mode = 1'b0;
  logic        pready, pslverr, system_reset, rerr;
  logic [3:0]  dv = 4'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  int          n_mismatch = 0, compares = 0, nrst = 0, n, c;
  always #5 pclk = ~pclk;
  // slow source at a sixteenth of pclk keeps overflow runs short
  always @(posedge pclk) dv <= dv + 4'h1;
  always @(posedge pclk) nrst <= nrst + system_reset;
  swd_software_watchdog_timer #(.BUS_SHORT_COUNT(19'h00010), .BUS_LONG_COUNT(19'h00040),
    .SLOW_LONG_COUNT(19'h00020)) swd_software_watchdog_timer_inst (.*, .slow_clk_pin(dv[3]));
  task ck(input string s, input logic [31:0] e, g);
    compares++;
    if (e !== g) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  // one apb transfer; data taken at the edge where pready is seen
  task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input string s, input logic [7:0] a, input logic [31:0] e);
    xf(1'b0, a, 32'h0);
    ck(s, e, rdat);
  endtask
  // cycles until the overflow pulse, bounded
  task wt(output int k, input int lim);
    k = 0;
    while (system_reset !== 1'b1 && k < lim) begin
      @(posedge pclk);
      k++;
    end
  endtask
  task test_done;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    // the short slow time-out alone takes about 16400 cycles
    #250000;
    n_mismatch++;
    test_done;
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    wt(n, 2000);
    // 32 slow ticks of 16 cycles; the phase of the first tick is free
    ck("slow_ovf", 1, n >= 497 && n <= 514);
    rd("opt_one", 8'h00, 32'hC0);
    rd("opt_two", 8'h04, 32'h0);
    rd("status", 8'h08, 32'h20);
    rd("unmapped", 8'h10, 32'h0);
    ck("err", 1, rerr);
    xf(1'b1, 8'h04, 32'h80);
    xf(1'b1, 8'h00, 32'h80);
    wt(n, 2000);
    ck("bus_ovf", 1, n > 13 && n < 19);
    xf(1'b1, 8'h00, 32'h0);
    rd("locked", 8'h00, 32'h80);
    c = nrst;
    // services come from the main sequence, never from an interrupt path
    repeat (6) begin
      xf(1'b1, 8'h08, 32'hFFFFFFFF);
      repeat (9) @(posedge pclk);
    end
    ck("serviced", c, nrst);
    rd("status_kept", 8'h08, 32'h20);
    // debug first, then stop with the bus clock; both must freeze the count
    for (int i = 0; i < 2; i++) begin
      xf(1'b1, 8'h08, 32'h0);
      // let the count leave zero so that a hold differs from a clear
      repeat (5) @(posedge pclk);
      {stop_mode, debug_mode} <= 2'b01 << i;
      xf(1'b0, 8'h0C, 32'h0);
      c = rdat;
      ck("ran", 1, c != 0);
      repeat (30) @(posedge pclk);
      rd("frozen", 8'h0C, c);
      {stop_mode, debug_mode} <= 2'b00;
    end
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd("reset_again", 8'h00, 32'hC0);
    repeat (100) @(posedge pclk);
    stop_mode <= 1'b1;
    rd("stop_clear", 8'h0C, 32'h0);
    stop_mode <= 1'b0;
    xf(1'b1, 8'h00, 32'h0);
    c = nrst;
    repeat (700) @(posedge pclk);
    ck("disabled", c, nrst);
    rd("count_zero", 8'h0C, 32'h0);
    // slow source with the short time-out: 1024 ticks of 16 cycles
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    xf(1'b1, 8'h00, 32'h80);
    wt(n, 17000);
    ck("slow_short", 1, n >= 16368 && n <= 16400);
    test_done;
  end
endmodule // tb_software_watchdog_timer
bind swd_software_watchdog_timer swd_chk swd_chk_inst (.*);
`default_nettype wire
